/* ccms_regs.vh */
// Constants for the CPU clock mode select block
`ifndef CCMS_REGS_VH
`define CCMS_REGS_VH

// Register byte offsets on the APB
`define CCMS_OFF_STATUS 8'h00
`define CCMS_OFF_RANGE_SEL 8'h04
`define CCMS_OFF_PERIOD 8'h08
`define CCMS_OFF_CFG_BASE 8'h10
`define CCMS_OFF_CFG_LAST 8'h1C

// Address layout
`define CCMS_ADDR_W 8
`define CCMS_WORD_LSB 2
`define CCMS_CFG_IDX_W 2
`define CCMS_CFG_NUM 4

// Bus range config fields
`define CCMS_CFG_W 6
`define CCMS_CFG_WAIT_MSB 3
`define CCMS_CFG_WAIT_LSB 0
`define CCMS_CFG_TRI_BIT 4
`define CCMS_CFG_ALE_BIT 5
`define CCMS_CFG_RESET 6'h00

// Stretch arithmetic
`define CCMS_WAIT_TOP 5'h0F
`define CCMS_TRI_TOP 2'h1

// Status fields
`define CCMS_ST_MODE_MSB 2
`define CCMS_ST_MODE_LSB 0
`define CCMS_ST_MULT_BIT 3
`define CCMS_ST_PRESC_BIT 4
`define CCMS_ST_DIRECT_BIT 5

// Sampled mode codes
`define CCMS_MODE_X4 3'h7
`define CCMS_MODE_X3 3'h6
`define CCMS_MODE_X2 3'h5
`define CCMS_MODE_X5 3'h4
`define CCMS_MODE_DIRECT 3'h3
`define CCMS_MODE_X1P5 3'h2
`define CCMS_MODE_PRESC 3'h1
`define CCMS_MODE_X2P5 3'h0

// Factor in halves, and phases per input period equal twice the factor
`define CCMS_F2_X4 4'h8
`define CCMS_F2_X3 4'h6
`define CCMS_F2_X2 4'h4
`define CCMS_F2_X5 4'hA
`define CCMS_F2_X1P5 4'h3
`define CCMS_F2_X2P5 4'h5
`define CCMS_F2_NONE 4'h2

// Period measurement
`define CCMS_PER_W 16
`define CCMS_PER_RESET 16'h0010
`define CCMS_PER_MAX 16'hFFFF

`endif

/* ccms_sync.v */
// Two flip-flop synchroniser for pin inputs
module ccms_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_b_i,
   // Asynchronous levels in, synchronous levels out
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1)
      begin : bit_sync
         reg meta_reg; // First stage, read only by second stage
         reg hold_reg; // Second stage, safe to use
         // One chain per bit
         always @(posedge clk_i)
         begin
            if (!rst_b_i)
            begin
               meta_reg <= 1'b0;
               hold_reg <= 1'b0;
            end
            else
            begin
               meta_reg <= async_i[g];
               hold_reg <= meta_reg;
            end
         end
         assign sync_o[g] = hold_reg;
      end
   endgenerate
endmodule

/* ccms_cfgram.v */
// Small memory holding the bus range configuration words
`include "ccms_regs.vh"
module ccms_cfgram (
   // Clock
   input wire clk_i,
   // Write port
   input wire wr_en_i,
   input wire [`CCMS_CFG_IDX_W-1:0] wr_idx_i,
   input wire [`CCMS_CFG_W-1:0] wr_data_i,
   // Read port, data registered
   input wire [`CCMS_CFG_IDX_W-1:0] rd_idx_i,
   output reg [`CCMS_CFG_W-1:0] rd_data_o
);
   reg [`CCMS_CFG_W-1:0] mem [0:`CCMS_CFG_NUM-1]; // Storage words
   integer i;
   // Initial contents cleared for simulation start
   initial
   begin
      for (i = 0; i < `CCMS_CFG_NUM; i = i + 1)
         mem[i] = `CCMS_CFG_RESET;
      rd_data_o = `CCMS_CFG_RESET;
   end
   // Write and registered read
   always @(posedge clk_i)
   begin
      if (wr_en_i)
         mem[wr_idx_i] <= wr_data_i;
      rd_data_o <= mem[rd_idx_i];
   end
endmodule

/* ccms_top.v */
// CPU clock mode select: strap sampling, clock paths, bus stretch decode
//
// Behaviour
// - Sample three mode pins during reset
// - Code 001 divides input by two
// - Code 011 passes input straight through
// - Other codes multiply by the table factor
// - Every CPU clock edge is one phase tick
// - Multiplier resyncs every F transitions, gradually
// - Direct drive: two phases equal one period
// - Stretch amounts come from range config registers
// - Stretch: ALE count, 2(15-wait), 2(1-tri)
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`include "ccms_regs.vh"
module ccms_top (
   // Clock and reset
   input wire CLOCK_I,
   input wire RST_B_I,
   // APB slave
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire [`CCMS_ADDR_W-1:0] PADDR_I,
   input wire [31:0] PWDATA_I,
   output reg [31:0] PRDATA_O,
   output wire PREADY_O,
   output reg PSLVERR_O,
   // Oscillator and mode pins
   input wire XTAL_I,
   input wire [2:0] CLOCK_MODE_PINS_I,
   // Generated CPU clock
   output reg CPU_CLK_O,
   output reg PHASE_TICK_O,
   output reg MULT_EN_O,
   output reg [2:0] CLOCK_MODE_O,
   // Stretch of the selected bus range, in phases
   output reg [1:0] ALE_EXT_PHASES_O,
   output reg [4:0] WAIT_PHASES_O,
   output reg [1:0] TRISTATE_PHASES_O
);
   // Factor in halves for a mode code
   function [3:0] ccms_factor2;
      input [2:0] code;
      begin
         case (code)
            `CCMS_MODE_X4: ccms_factor2 = `CCMS_F2_X4;
            `CCMS_MODE_X3: ccms_factor2 = `CCMS_F2_X3;
            `CCMS_MODE_X2: ccms_factor2 = `CCMS_F2_X2;
            `CCMS_MODE_X5: ccms_factor2 = `CCMS_F2_X5;
            `CCMS_MODE_X1P5: ccms_factor2 = `CCMS_F2_X1P5;
            `CCMS_MODE_X2P5: ccms_factor2 = `CCMS_F2_X2P5;
            default: ccms_factor2 = `CCMS_F2_NONE;
         endcase
      end
   endfunction

   // Word address belongs to the config block
   function ccms_is_cfg;
      input [`CCMS_ADDR_W-1:0] addr;
      begin
         ccms_is_cfg = (addr >= `CCMS_OFF_CFG_BASE) && (addr <= `CCMS_OFF_CFG_LAST)
            && (addr[1:0] == 2'h0);
      end
   endfunction

   // Path states, one-hot
   localparam ST_PRESC = 3'h1;
   localparam ST_DIRECT = 3'h2;
   localparam ST_MULT = 3'h4;

   // Synchronised pins
   wire xtal_s; // Oscillator level after two flops
   wire [2:0] mode_pins_s; // Mode pins after two flops
   ccms_sync #(.WIDTH(1)) u_sync_xtal (
      .clk_i(CLOCK_I),
      .rst_b_i(1'b1),
      .async_i(XTAL_I),
      .sync_o(xtal_s)
   );
   ccms_sync #(.WIDTH(3)) u_sync_mode (
      .clk_i(CLOCK_I),
      .rst_b_i(1'b1),
      .async_i(CLOCK_MODE_PINS_I),
      .sync_o(mode_pins_s)
   );

   // Mode and path state
   reg [2:0] mode_reg; // Latched strap code
   reg [2:0] path_reg; // Active path, one-hot
   reg [2:0] path_next;
   wire [3:0] f2 = ccms_factor2(mode_reg); // Factor in halves

   // Strap capture: pins keep being sampled while reset is low, last value stays
   always @(posedge CLOCK_I)
   begin
      if (!RST_B_I)
         mode_reg <= mode_pins_s;
      // Otherwise hold; pin changes after reset are ignored
   end

   // Path decode from the held code
   always @*
   begin
      case (mode_reg)
         `CCMS_MODE_PRESC: path_next = ST_PRESC;
         `CCMS_MODE_DIRECT: path_next = ST_DIRECT;
         default: path_next = ST_MULT;
      endcase
   end

   // Path register
   always @(posedge CLOCK_I)
   begin
      if (!RST_B_I)
         path_reg <= ST_MULT;
      else
         path_reg <= path_next;
   end

   // Input edge detection on the synchronised level
   reg xtal_d_reg; // Previous input level
   wire xtal_rise = xtal_s & ~xtal_d_reg;
   wire xtal_fall = ~xtal_s & xtal_d_reg;
   wire xtal_edge = xtal_rise | xtal_fall;

   // Period measurement and gradual tracking
   reg [`CCMS_PER_W-1:0] per_cnt_reg; // Clocks since last rising edge
   reg [`CCMS_PER_W-1:0] per_reg; // Tracked period, moves one step per period
   reg [4:0] trans_reg; // Transitions counted in halves

   // Tracking by single steps avoids abrupt CPU frequency jumps
   always @(posedge CLOCK_I)
   begin
      if (!RST_B_I)
      begin
         xtal_d_reg <= xtal_s; // Tracks the pin in reset, so no false edge follows
         per_cnt_reg <= {`CCMS_PER_W{1'b0}};
         per_reg <= `CCMS_PER_RESET;
      end
      else
      begin
         xtal_d_reg <= xtal_s;
         if (xtal_rise)
         begin
            per_cnt_reg <= {`CCMS_PER_W{1'b0}};
            if (per_cnt_reg + 16'h0001 > per_reg)
               per_reg <= per_reg + 16'h0001;
            else if (per_cnt_reg + 16'h0001 < per_reg)
               per_reg <= per_reg - 16'h0001;
         end
         else if (per_cnt_reg != `CCMS_PER_MAX)
            per_cnt_reg <= per_cnt_reg + 16'h0001;
      end
   end

   // Multiplier phase accumulator: 2F phases per tracked input period
   reg [`CCMS_PER_W:0] acc_reg; // Fractional phase position
   wire [`CCMS_PER_W:0] acc_sum = acc_reg + {13'h0000, f2};
   wire mult_tick = (acc_sum >= {1'b0, per_reg});
   wire [4:0] trans_sum = trans_reg + 5'h02; // One transition is two halves
   wire resync_now = xtal_edge && (trans_sum >= {1'b0, f2});
   // Residue after this cycle's tick, and half a tracked period for the pull direction
   wire [`CCMS_PER_W:0] acc_after = mult_tick ? acc_sum - {1'b0, per_reg} : acc_sum;
   wire [`CCMS_PER_W:0] acc_half = {2'b00, per_reg[`CCMS_PER_W-1:1]};
   wire [`CCMS_PER_W:0] acc_step = {{`CCMS_PER_W{1'b0}}, 1'b1}; // One unit of phase
   wire acc_zero = (acc_after == {(`CCMS_PER_W+1){1'b0}}); // Already on an edge
   wire acc_early = !acc_zero && (acc_after < acc_half); // CPU edge came a bit early
   wire acc_late = !acc_zero && (acc_after >= acc_half); // CPU edge is still due

   // Accumulator and transition counter
   always @(posedge CLOCK_I)
   begin
      if (!RST_B_I)
      begin
         acc_reg <= {(`CCMS_PER_W+1){1'b0}};
         trans_reg <= 5'h00;
      end
      else
      begin
         if (xtal_edge)
            trans_reg <= resync_now ? trans_sum - {1'b0, f2} : trans_sum;
         // Every Fth transition the phase is pulled one unit toward the input edge;
         // a hard realign would insert a short phase and extra ticks at odd factors
         if (resync_now && acc_early)
            acc_reg <= acc_after - acc_step;
         else if (resync_now && acc_late)
            acc_reg <= acc_after + acc_step;
         else
            acc_reg <= acc_after;
      end
   end

   // CPU clock and phase tick; every edge of the CPU clock is one phase
   reg tick_next;
   always @*
   begin
      case (path_reg)
         ST_PRESC: tick_next = xtal_rise; // Phase is one input period
         ST_DIRECT: tick_next = xtal_edge; // Edge pair spans one period
         ST_MULT: tick_next = mult_tick; // Phase pull keeps it locked
         default: tick_next = 1'b0;
      endcase
   end

   // Output clock register; limited to half the system clock rate
   always @(posedge CLOCK_I)
   begin
      if (!RST_B_I)
      begin
         CPU_CLK_O <= 1'b0;
         PHASE_TICK_O <= 1'b0;
         MULT_EN_O <= 1'b0;
         CLOCK_MODE_O <= 3'h0;
      end
      else
      begin
         PHASE_TICK_O <= tick_next;
         if (path_reg == ST_DIRECT)
            CPU_CLK_O <= xtal_s; // Follows input duty cycle
         else if (tick_next)
            CPU_CLK_O <= ~CPU_CLK_O;
         MULT_EN_O <= (path_reg == ST_MULT);
         CLOCK_MODE_O <= mode_reg;
      end
   end

   // APB: one wait cycle per access so the config memory can answer
   reg ready_reg; // Access phase answered
   reg [1:0] range_sel_reg; // Range whose stretch drives the outputs
   wire access = PSEL_I & PENABLE_I;
   wire commit = access & ready_reg;
   wire mapped = ccms_is_cfg(PADDR_I) || (PADDR_I == `CCMS_OFF_STATUS)
      || (PADDR_I == `CCMS_OFF_RANGE_SEL) || (PADDR_I == `CCMS_OFF_PERIOD);
   wire [`CCMS_CFG_IDX_W-1:0] cfg_idx = PADDR_I[`CCMS_WORD_LSB+`CCMS_CFG_IDX_W-1:`CCMS_WORD_LSB];
   wire [`CCMS_CFG_IDX_W-1:0] rd_idx = PSEL_I ? cfg_idx : range_sel_reg;
   wire [`CCMS_CFG_W-1:0] cfg_rd; // Registered memory data
   reg rd_own_reg; // Memory data belongs to the selected range
   assign PREADY_O = ready_reg;

   // Bus range configuration words
   ccms_cfgram u_cfgram (
      .clk_i(CLOCK_I),
      .wr_en_i(commit & PWRITE_I & ccms_is_cfg(PADDR_I)),
      .wr_idx_i(cfg_idx),
      .wr_data_i(PWDATA_I[`CCMS_CFG_W-1:0]),
      .rd_idx_i(rd_idx),
      .rd_data_o(cfg_rd)
   );

   // Read data mux
   reg [31:0] rdata_next;
   always @*
   begin
      rdata_next = 32'h00000000;
      if (ccms_is_cfg(PADDR_I))
         rdata_next[`CCMS_CFG_W-1:0] = cfg_rd;
      else if (PADDR_I == `CCMS_OFF_STATUS)
      begin
         rdata_next[`CCMS_ST_MODE_MSB:`CCMS_ST_MODE_LSB] = mode_reg;
         rdata_next[`CCMS_ST_MULT_BIT] = (path_reg == ST_MULT);
         rdata_next[`CCMS_ST_PRESC_BIT] = (path_reg == ST_PRESC);
         rdata_next[`CCMS_ST_DIRECT_BIT] = (path_reg == ST_DIRECT);
      end
      else if (PADDR_I == `CCMS_OFF_RANGE_SEL)
         rdata_next[1:0] = range_sel_reg;
      else if (PADDR_I == `CCMS_OFF_PERIOD)
         rdata_next[`CCMS_PER_W-1:0] = per_reg;
   end

   // Handshake, read capture and range select register
   always @(posedge CLOCK_I)
   begin
      if (!RST_B_I)
      begin
         ready_reg <= 1'b0;
         PRDATA_O <= 32'h00000000;
         PSLVERR_O <= 1'b0;
         range_sel_reg <= 2'h0;
         rd_own_reg <= 1'b0;
      end
      else
      begin
         ready_reg <= access & ~ready_reg;
         rd_own_reg <= ~PSEL_I;
         if (access & ~ready_reg)
         begin
            PRDATA_O <= PWRITE_I ? 32'h00000000 : rdata_next;
            PSLVERR_O <= ~mapped; // Unmapped address answers with an error
         end
         if (commit & PWRITE_I & (PADDR_I == `CCMS_OFF_RANGE_SEL))
            range_sel_reg <= PWDATA_I[1:0];
      end
   end

   // Remaining wait and tristate steps of the selected range
   wire [4:0] wait_left = `CCMS_WAIT_TOP
      - {1'b0, cfg_rd[`CCMS_CFG_WAIT_MSB:`CCMS_CFG_WAIT_LSB]};
   wire [1:0] tri_left = `CCMS_TRI_TOP - {1'b0, cfg_rd[`CCMS_CFG_TRI_BIT]};

   // Stretch decode; updated only from reads of the selected range
   always @(posedge CLOCK_I)
   begin
      if (!RST_B_I)
      begin
         ALE_EXT_PHASES_O <= 2'h0;
         WAIT_PHASES_O <= 5'h1E;
         TRISTATE_PHASES_O <= 2'h2;
      end
      else if (rd_own_reg)
      begin
         ALE_EXT_PHASES_O <= {1'b0, cfg_rd[`CCMS_CFG_ALE_BIT]};
         WAIT_PHASES_O <= {wait_left[3:0], 1'b0};
         TRISTATE_PHASES_O <= {tri_left[0], 1'b0};
      end
   end
endmodule

/* ccms_osc.sv */
// Oscillator model feeding the input clock pin
module ccms_osc (
   // System clock
   input wire logic clk_i,
   // High and low time in system clocks
   input wire logic [31:0] hi_i,
   input wire logic [31:0] lo_i,
   // Oscillator level
   output logic xtal_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0; // Clocks into this level
   initial xtal_o = 1'b0;
   // Runs free, so duty can be made uneven
   always @(posedge clk_i)
   begin
      cnt <= cnt + 1;
      if (cnt + 1 >= (xtal_o ? hi_i : lo_i))
      begin
         xtal_o <= ~xtal_o;
         cnt <= 0;
      end
   end
endmodule

/* ccms_top_properties.sv */
// Port checker for the CPU clock mode select block
module ccms_chk (
   // Clock and reset
   input wire CLOCK_I,
   input wire RST_B_I,
   // APB
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire [7:0] PADDR_I,
   input wire PREADY_O,
   input wire PSLVERR_O,
   // Clock path
   input wire XTAL_I,
   input wire CPU_CLK_O,
   input wire PHASE_TICK_O,
   input wire MULT_EN_O,
   input wire [2:0] CLOCK_MODE_O,
   // Stretch
   input wire [1:0] ALE_EXT_PHASES_O,
   input wire [4:0] WAIT_PHASES_O,
   input wire [1:0] TRISTATE_PHASES_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);
   a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
      else $error("ready held too long");
   a_ready_wait: assert property (PSEL_I && PENABLE_I && !$past(PENABLE_I)
      |-> !PREADY_O ##1 PREADY_O) else $error("ready not on second access cycle");
   a_err_decode: assert property (PREADY_O |-> PSLVERR_O == !(PADDR_I inside
      {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C}))
      else $error("error flag wrong for address");
   a_mode_hold: assert property ($past(RST_B_I, 2) |-> $stable(CLOCK_MODE_O))
      else $error("mode changed outside reset");
   a_mult_sel: assert property ($past(RST_B_I, 2) |->
      MULT_EN_O == !(CLOCK_MODE_O inside {3'h1, 3'h3})) else $error("multiplier enable wrong");
   a_tick_edge: assert property ($past(RST_B_I, 4) |->
      PHASE_TICK_O == (CPU_CLK_O != $past(CPU_CLK_O))) else $error("tick not at clock edge");
   a_stretch_val: assert property (!WAIT_PHASES_O[0] && WAIT_PHASES_O <= 5'h1E &&
      !TRISTATE_PHASES_O[0] && ALE_EXT_PHASES_O <= 2'h1) else $error("stretch value illegal");
   a_presc_fall: assert property (CLOCK_MODE_O == 3'h1 && $fell(XTAL_I)
      |-> ##3 !PHASE_TICK_O [*3]) else $error("prescaler ticked on falling input");
   a_direct_fall: assert property (CLOCK_MODE_O == 3'h3 && $fell(XTAL_I)
      |-> ##[3:5] PHASE_TICK_O) else $error("direct drive missed falling input");
endmodule
bind ccms_top ccms_chk i_ccms_chk (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .XTAL_I(XTAL_I), .CPU_CLK_O(CPU_CLK_O), .PHASE_TICK_O(PHASE_TICK_O),
   .MULT_EN_O(MULT_EN_O), .CLOCK_MODE_O(CLOCK_MODE_O), .ALE_EXT_PHASES_O(ALE_EXT_PHASES_O),
   .WAIT_PHASES_O(WAIT_PHASES_O), .TRISTATE_PHASES_O(TRISTATE_PHASES_O));

/* ccms_top_tb.sv */
// Self-checking bench for the CPU clock mode select block
module ccms_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, seed = 32'h1D;
   logic pready, pslverr, xtal, cpu_clk, tick, mult;
   logic [2:0] pins = 3'h7, mode;
   logic [1:0] ale, tri_ph;
   logic [4:0] wait_ph;
   logic [5:0] v[4]; // Range config words written
   logic [33:0] exp_q[$]; // Data-check flag, error, data
   int hi = 12, lo = 28, err_total = 0, total_checks = 0, ticks = 0, n0;
   int ph[8] = '{5, 1, 3, 2, 10, 4, 6, 8}; // Phases per input period by code
   ccms_top i_ccms_top (.CLOCK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .XTAL_I(xtal), .CLOCK_MODE_PINS_I(pins),
      .CPU_CLK_O(cpu_clk), .PHASE_TICK_O(tick), .MULT_EN_O(mult), .CLOCK_MODE_O(mode),
      .ALE_EXT_PHASES_O(ale), .WAIT_PHASES_O(wait_ph), .TRISTATE_PHASES_O(tri_ph));
   ccms_osc i_ccms_osc (.clk_i(clk), .hi_i(hi), .lo_i(lo), .xtal_o(xtal));
   // System clock
   initial forever #20 clk = ~clk;
   // Xorshift source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Compare and count
   task automatic chk(string nm, logic [32:0] e, logic [32:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Range compare, for counts that drift by a unit or two
   task automatic rng(string nm, int e, int d, int g);
      total_checks++;
      if (g < e - d || g > e + d)
      begin
         err_total++;
         $display("[ERR] %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   // APB transfer; held until ready is sampled high
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [33:0] e);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      exp_q.push_back(e);
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // Answer watcher takes the oldest note
   always @(posedge clk)
   begin
      if (tick === 1'b1)
         ticks <= ticks + 1;
      if (psel && pen && pready === 1'b1)
      begin
         chk("slverr", exp_q[0][32], pslverr);
         if (exp_q[0][33])
            chk("prdata", exp_q[0][31:0], prdata);
         void'(exp_q.pop_front());
      end
   end
   // Verdict
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Hang guard, about four and a half times the expected run
   initial
   begin
      repeat (60000) @(posedge clk);
      err_total++;
      stop_test();
   end
   // Main sequence
   initial
   begin
      for (int m = 0; m < 8; m++)
      begin
         pins <= m[2:0];
         rst_b <= 1'b0;
         repeat (6) @(posedge clk);
         rst_b <= 1'b1;
         @(posedge clk);
         pins <= 3'(rnd());
         apb(0, 8'h00, 0, {2'b10, 26'h0, m == 3, m == 1, !(m == 1 || m == 3), m[2:0]});
         chk("mode", m[2:0], mode);
         repeat (30 * (hi + lo)) @(posedge clk);
         n0 = ticks;
         repeat (10 * (hi + lo)) @(posedge clk);
         rng("ticks", 10 * ph[m], 2, ticks - n0);
         apb(0, 8'h08, 0, {2'b00, 32'h0});
         if (m != 1 && m != 3)
            rng("period", hi + lo, 1, prdata);
         $display("mode %0d done", m);
      end
      apb(1, 8'h0C, 32'h1, {2'b01, 32'h0});
      apb(0, 8'h0C, 0, {2'b11, 32'h0});
      apb(1, 8'h00, 32'hFF, {2'b00, 32'h0});
      apb(0, 8'h00, 0, {2'b10, 32'h0000000F});
      apb(0, 8'h04, 0, {2'b10, 32'h0});
      for (int r = 0; r < 4; r++)
      begin
         v[r] = (r == 0) ? 6'h3F : (r == 1) ? 6'h00 : 6'(rnd());
         apb(1, 8'(8'h10 + 4 * r), {26'h0, v[r]}, {2'b00, 32'h0});
      end
      for (int r = 0; r < 4; r++)
      begin
         apb(0, 8'(8'h10 + 4 * r), 0, {2'b10, 26'h0, v[r]});
         apb(1, 8'h04, r, {2'b00, 32'h0});
         repeat (4) @(posedge clk);
         chk("ale", 2'(v[r][5]), ale);
         chk("wait", 5'(2 * (15 - v[r][3:0])), wait_ph);
         chk("tri", 2'(2 * (1 - v[r][4])), tri_ph);
      end
      $display("registers done");
      stop_test();
   end
endmodule
